/* hdl/safety_eval_pkg.sv */
// Purpose: Constants for the safety input evaluator
// Assumes: 100 MHz clock
// Notes:   Times in their own unit, cycle counts derived
package safety_eval_pkg;
	localparam int unsigned CLK_MHZ            = 100;
	localparam int unsigned SYNC_TIME_MS       = 500;
	localparam int unsigned INTERLOCK_TIME_MS  = 200;
	localparam int unsigned INTERLOCK_CLEAR_MS = 1000;
	localparam int unsigned ACT_DELAY_MS       = 50;
	localparam int unsigned SYNC_CYC           = SYNC_TIME_MS * CLK_MHZ * 1000;
	localparam int unsigned INTERLOCK_CYC      = INTERLOCK_TIME_MS * CLK_MHZ * 1000;
	localparam int unsigned CLEAR_CYC          = INTERLOCK_CLEAR_MS * CLK_MHZ * 1000;
	localparam int unsigned ACT_DELAY_CYC      = ACT_DELAY_MS * CLK_MHZ * 1000;
	localparam int unsigned CNT_W              = 32;

	// Register map
	localparam logic [3:0]  ADDR_CTRL          = 4'h0;
	localparam logic [3:0]  ADDR_STATUS        = 4'h4;
	localparam logic [3:0]  ADDR_CLEAR         = 4'h8;
	localparam int unsigned CTRL_SYNC_EN_BIT   = 0;
	localparam int unsigned CTRL_LOCK_EN_BIT   = 1;
	localparam int unsigned CTRL_ANTIV_BIT     = 2;
	localparam int unsigned CTRL_AUTO_BIT      = 3;
	localparam logic [3:0]  CTRL_RESET         = 4'h7;
	localparam int unsigned ST_OUT_BIT         = 0;
	localparam int unsigned ST_ERR_BIT         = 1;
	localparam int unsigned ST_SYNC_ALERT_BIT  = 2;
	localparam int unsigned ST_ANTIV_ALERT_BIT = 3;
	localparam int unsigned ST_LOCK_ALERT_BIT  = 4;
	localparam int unsigned ST_IN_A_BIT        = 5;
	localparam int unsigned ST_IN_B_BIT        = 6;

	typedef enum logic [1:0] {
		ST_DEENERGIZED = 2'b00,
		ST_ENERGIZED   = 2'b01,
		ST_ERROR       = 2'b10
	} run_state_e;
endpackage : safety_eval_pkg

/* hdl/safety_input_evaluator.sv */
// Purpose: Evaluates two safety inputs and drives the safety output
// Assumes: Inputs synchronous to clk_i; Avalon-MM register access
// Notes:   Times are parameters so a bench can shorten them
//
// Notes on behaviour
// - With sync enabled, second input must activate within sync time of first.
// - Both inputs active but no start: output stays off, safe state.
// - Start met with valid inputs energizes output within activation delay.
// - Input deactivation while energized drops output within response time.
// - Activation permits energizing; deactivation forces de-energized state.
// - Antivalent mode pairs one normally open and one normally closed channel.
// - Normally open 0 and normally closed 1 decode as activated.
// - Normally open 1 and normally closed 0 decode as deactivated.
// - Identical channel levels beyond sync time raise an antivalence alert.
// - Interlock window 200 ms; both not deactivated raises alert, blocks energizing.
// - Interlock clears only after both inputs deactivated at least one second.
// - A sync or antivalence alert moves to error state with outputs off; an interlock alert only blocks energizing.
// - Re-energize after deactivation only with start and inputs activated again.
`timescale 1ns/100ps
module safety_input_evaluator
	import safety_eval_pkg::*;
#(
	parameter int unsigned SYNC_CYCLES  = SYNC_CYC,
	parameter int unsigned LOCK_CYCLES  = INTERLOCK_CYC,
	parameter int unsigned CLEAR_CYCLES = CLEAR_CYC,
	parameter int unsigned ACT_CYCLES   = ACT_DELAY_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [1:0]  normally_open_channel_i,
	input  wire logic [1:0]  normally_closed_channel_i,
	input  wire logic        start_i,
	output logic             safety_output_o,
	input  wire logic [3:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	output logic [31:0]      readdata_o,
	output logic             waitrequest_o
);

	////////////////////////////////////////////////////////////////////////
	// Channel decode
	function automatic logic decode_active(input logic no_ch, input logic nc_ch, input logic antiv);
		// Equivalent mode reads both as normally closed
		if (antiv)
			return (no_ch == 1'b0) && (nc_ch == 1'b1);
		return no_ch && nc_ch;
	endfunction : decode_active

	function automatic logic count_done(input logic [CNT_W-1:0] cnt, input int unsigned lim);
		return cnt >= lim[CNT_W-1:0];
	endfunction : count_done

	logic [3:0]  ctrl_q;
	logic        sync_en;
	logic        lock_en;
	logic        antiv_en;
	logic        auto_start;
	assign sync_en    = ctrl_q[CTRL_SYNC_EN_BIT];
	assign lock_en    = ctrl_q[CTRL_LOCK_EN_BIT];
	assign antiv_en   = ctrl_q[CTRL_ANTIV_BIT];
	assign auto_start = ctrl_q[CTRL_AUTO_BIT];

	logic [1:0] act;
	logic [1:0] mismatch;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			act[i]      = decode_active(normally_open_channel_i[i], normally_closed_channel_i[i], antiv_en);
			mismatch[i] = antiv_en && (normally_open_channel_i[i] == normally_closed_channel_i[i]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Antivalence timing, per input
	logic [CNT_W-1:0] same_cnt_q [2];
	logic             antiv_alert_q;
	logic             clear_req;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			same_cnt_q[0] <= '0;
			same_cnt_q[1] <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!mismatch[i])
					same_cnt_q[i] <= '0;
				else if (!count_done(same_cnt_q[i], SYNC_CYCLES))
					same_cnt_q[i] <= same_cnt_q[i] + 1'b1;
			end
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			antiv_alert_q <= 1'b0;
		else if (count_done(same_cnt_q[0], SYNC_CYCLES) || count_done(same_cnt_q[1], SYNC_CYCLES))
			antiv_alert_q <= 1'b1;
		else if (clear_req)
			antiv_alert_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Two-input synchronisation
	logic [CNT_W-1:0] sync_cnt_q;
	logic             sync_ok_q;
	logic             sync_alert_q;
	logic [1:0]       act_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			act_q <= 2'b00;
		else
			act_q <= act;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_cnt_q <= '0;
			sync_ok_q  <= 1'b0;
		end else if (act == 2'b00) begin
			sync_cnt_q <= '0;
			sync_ok_q  <= 1'b0;
		end else if (act == 2'b11) begin
			// Judged once, at the moment the second input arrives
			if (act_q != 2'b11)
				sync_ok_q <= !count_done(sync_cnt_q, SYNC_CYCLES);
		end else begin
			sync_ok_q <= 1'b0;
			if (!count_done(sync_cnt_q, SYNC_CYCLES))
				sync_cnt_q <= sync_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			sync_alert_q <= 1'b0;
		else if (sync_en && act != 2'b11 && act != 2'b00 && count_done(sync_cnt_q, SYNC_CYCLES))
			sync_alert_q <= 1'b1;
		else if (clear_req)
			sync_alert_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Signal interlock monitoring
	logic [CNT_W-1:0] lock_cnt_q;
	logic             lock_run_q;
	logic             lock_alert_q;
	logic [CNT_W-1:0] off_cnt_q;
	logic             lock_fail;

	// Partner re-activating during the window also counts as a failure
	assign lock_fail = lock_run_q && ((act == 2'b11 && act_q != 2'b11) || count_done(lock_cnt_q, LOCK_CYCLES));

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lock_run_q <= 1'b0;
			lock_cnt_q <= '0;
		end else if (!lock_en || act == 2'b00 || lock_fail) begin
			lock_run_q <= 1'b0;
			lock_cnt_q <= '0;
		end else if (act_q == 2'b11 && act != 2'b11) begin
			lock_run_q <= 1'b1;
			lock_cnt_q <= '0;
		end else if (lock_run_q) begin
			lock_cnt_q <= lock_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			off_cnt_q <= '0;
		else if (act != 2'b00)
			off_cnt_q <= '0;
		else if (!count_done(off_cnt_q, CLEAR_CYCLES))
			off_cnt_q <= off_cnt_q + 1'b1;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			lock_alert_q <= 1'b0;
		else if (lock_fail)
			lock_alert_q <= 1'b1;
		else if (act == 2'b00 && count_done(off_cnt_q, CLEAR_CYCLES))
			lock_alert_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Run state machine
	run_state_e       state_q;
	logic             err;
	logic             permit;
	logic             start_ok;
	logic             rearm_q;
	logic [CNT_W-1:0] act_cnt_q;

	assign err      = antiv_alert_q || sync_alert_q;
	assign start_ok = auto_start || start_i;
	assign permit   = (act == 2'b11) && rearm_q && !lock_alert_q && (!sync_en || sync_ok_q);

	// Rearm after both inputs seen deactivated
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rearm_q <= 1'b0;
		else if (act == 2'b00)
			rearm_q <= 1'b1;
		else if (state_q == ST_ENERGIZED && act != 2'b11)
			rearm_q <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			act_cnt_q <= '0;
		else if (state_q == ST_DEENERGIZED && permit && start_ok)
			act_cnt_q <= act_cnt_q + 1'b1;
		else
			act_cnt_q <= '0;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= ST_DEENERGIZED;
		end else begin
			case (state_q)
				ST_DEENERGIZED: begin
					if (err)
						state_q <= ST_ERROR;
					else if (permit && start_ok && act_cnt_q + 1'b1 >= ACT_CYCLES[CNT_W-1:0])
						state_q <= ST_ENERGIZED;
				end
				ST_ENERGIZED: begin
					if (err)
						state_q <= ST_ERROR;
					else if (act != 2'b11)
						state_q <= ST_DEENERGIZED;
				end
				ST_ERROR: begin
					if (!err)
						state_q <= ST_DEENERGIZED;
				end
				default: state_q <= ST_DEENERGIZED;
			endcase
		end
	end

	// Output off in the same cycle an input drops
	assign safety_output_o = (state_q == ST_ENERGIZED) && (act == 2'b11) && !err;

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave; registered read data costs one wait state
	logic rd_hold_q;
	assign waitrequest_o = read_i && !rd_hold_q;
	assign clear_req     = write_i && address_i == ADDR_CLEAR && writedata_i[0];

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			ctrl_q <= CTRL_RESET;
		else if (write_i && address_i == ADDR_CTRL)
			ctrl_q <= writedata_i[3:0];
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			readdata_o <= '0;
			rd_hold_q  <= 1'b0;
		end else begin
			readdata_o <= '0;
			rd_hold_q  <= read_i && !rd_hold_q;
			if (read_i && !rd_hold_q) begin
				case (address_i)
					ADDR_CTRL:   readdata_o <= {28'h0000000, ctrl_q};
					ADDR_STATUS: readdata_o <= {25'h0, act, lock_alert_q, antiv_alert_q, sync_alert_q,
						state_q == ST_ERROR, safety_output_o};
					default:     readdata_o <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_out_needs_inputs;
		@(posedge clk_i) disable iff (!reset_n_i)
		safety_output_o |-> act == 2'b11 && !lock_alert_q;
	endproperty
	a_out_needs_inputs: assert property (p_out_needs_inputs) else $error("Output on without active inputs");

	property p_drop_deenergizes;
		@(posedge clk_i) disable iff (!reset_n_i)
		(state_q == ST_ENERGIZED && act != 2'b11 && !err) |=> state_q == ST_DEENERGIZED;
	endproperty
	a_drop_deenergizes: assert property (p_drop_deenergizes) else $error("No de-energize on drop");

	property p_no_start_stays_off;
		@(posedge clk_i) disable iff (!reset_n_i)
		(state_q == ST_DEENERGIZED && !start_ok) |=> state_q != ST_ENERGIZED;
	endproperty
	a_no_start_stays_off: assert property (p_no_start_stays_off) else $error("Energized without start");

	property p_error_state;
		@(posedge clk_i) disable iff (!reset_n_i)
		(err && state_q != ST_ERROR) |=> state_q == ST_ERROR;
	endproperty
	a_error_state: assert property (p_error_state) else $error("Error not entered");

	property p_error_off;
		@(posedge clk_i) disable iff (!reset_n_i)
		err |-> !safety_output_o;
	endproperty
	a_error_off: assert property (p_error_off) else $error("Output on during alert");

	property p_lock_blocks;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(lock_alert_q) |-> !safety_output_o;
	endproperty
	a_lock_blocks: assert property (p_lock_blocks) else $error("Output on during interlock");

	property p_lock_clear;
		@(posedge clk_i) disable iff (!reset_n_i)
		$fell(lock_alert_q) |-> $past(act) == 2'b00 && $past(off_cnt_q) >= CLEAR_CYCLES;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("Interlock cleared early");

	property p_decode;
		@(posedge clk_i) disable iff (!reset_n_i)
		antiv_en |-> act[0] == (!normally_open_channel_i[0] && normally_closed_channel_i[0]);
	endproperty
	a_decode: assert property (p_decode) else $error("Antivalent decode wrong");

	property p_antiv_alert;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(antiv_alert_q) |-> $past(mismatch) != 2'b00;
	endproperty
	a_antiv_alert: assert property (p_antiv_alert) else $error("Antivalence alert without cause");
endmodule : safety_input_evaluator

/* tb/contact_model.sv */
// Purpose: Sensor contact pair model for two safety inputs
// Assumes: act_i bit set means that input is activated
// Notes:   stuck_i forces identical levels to model a welded contact
`timescale 1ns/100ps
module contact_model (
	input  wire logic [1:0] act_i,
	input  wire logic [1:0] stuck_i,
	output logic [1:0]      normally_open_channel_o,
	output logic [1:0]      normally_closed_channel_o
);
	// Contacts switch together, so no skew between the two channels
	always_comb begin
		normally_open_channel_o   = ~act_i | stuck_i;
		normally_closed_channel_o = act_i | stuck_i;
	end
endmodule : contact_model

/* tb/safety_input_evaluator_tb_top.sv */
// Purpose: Self-checking bench for the safety input evaluator
// Assumes: Reads take one wait state, data taken when waitrequest is low
// Notes:   Shortened counts through parameters
`timescale 1ns/100ps
module safety_input_evaluator_tb_top;
	import safety_eval_pkg::*;
	localparam int unsigned SYNC_N = 20;
	localparam int unsigned LOCK_N = 20;
	localparam int unsigned CLR_N  = 50;
	localparam int unsigned ACT_N  = 3;
	logic        clk_i;
	logic        reset_n_i;
	logic [1:0]  act;
	logic [1:0]  stuck;
	logic [1:0]  no_ch;
	logic [1:0]  nc_ch;
	logic        start;
	logic [3:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic        safety_output_o;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic [31:0] rdata;
	int          bad_count;
	int          checked;
	////////////////////////////////////////////////////////////////
	contact_model u_contact_model (
		.act_i                     (act),
		.stuck_i                   (stuck),
		.normally_open_channel_o   (no_ch),
		.normally_closed_channel_o (nc_ch)
	);
	safety_input_evaluator #(
		.SYNC_CYCLES  (SYNC_N),
		.LOCK_CYCLES  (LOCK_N),
		.CLEAR_CYCLES (CLR_N),
		.ACT_CYCLES   (ACT_N)
	) u_safety_input_evaluator (
		.clk_i                     (clk_i),
		.reset_n_i                 (reset_n_i),
		.normally_open_channel_i   (no_ch),
		.normally_closed_channel_i (nc_ch),
		.start_i                   (start),
		.safety_output_o           (safety_output_o),
		.address_i                 (address),
		.read_i                    (read),
		.write_i                   (write),
		.writedata_i               (writedata),
		.readdata_o                (readdata_o),
		.waitrequest_o             (waitrequest_o)
	);
	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		address   <= a;
		writedata <= d;
		write     <= 1'b1;
		// Only the watchdog ends a hung wait
		do @(posedge clk_i); while (waitrequest_o !== 1'b0);
		write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		address <= a;
		read    <= 1'b1;
		do @(posedge clk_i); while (waitrequest_o !== 1'b0);
		// Data stands at the edge that ends the wait
		d = readdata_o;
		read <= 1'b0;
	endtask : rd
	task automatic st(input int b, input logic e, input string nm);
		rd(ADDR_STATUS, rdata);
		chk(nm, {31'h0, rdata[b]}, {31'h0, e});
	endtask : st
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wait_cyc
	task automatic outc(input logic e);
		chk("output", {31'h0, safety_output_o}, {31'h0, e});
	endtask : outc
	task automatic setin(input logic [1:0] a);
		@(posedge clk_i);
		act <= a;
	endtask : setin
	task automatic press(input logic s);
		@(posedge clk_i);
		start <= s;
	endtask : press
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		wrap_up();
	end
	initial begin
		reset_n_i = 1'b0;
		act = 2'b00;
		stuck = 2'b00;
		start = 1'b0;
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		bad_count = 0;
		checked = 0;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(ADDR_CTRL, rdata);
		chk("ctrl reset", rdata, {28'h0, CTRL_RESET});
		rd(4'hc, rdata);
		chk("unmapped", rdata, 32'h0);
		$display("test reset done");
		// A then B inside the sync time, no start yet
		setin(2'b01);
		wait_cyc(5);
		setin(2'b11);
		wait_cyc(10);
		outc(1'b0);
		st(ST_IN_A_BIT, 1'b1, "input a");
		st(ST_IN_B_BIT, 1'b1, "input b");
		press(1'b1);
		wait_cyc(ACT_N + 2);
		outc(1'b1);
		press(1'b0);
		$display("test energize done");
		// Drop is combinational, so seen right after the edge
		setin(2'b01);
		#1;
		outc(1'b0);
		setin(2'b00);
		st(ST_IN_B_BIT, 1'b0, "input b");
		$display("test drop done");
		setin(2'b11);
		wait_cyc(10);
		outc(1'b0);
		press(1'b1);
		wait_cyc(ACT_N + 2);
		outc(1'b1);
		press(1'b0);
		setin(2'b00);
		$display("test rearm done");
		// Second input far too late
		setin(2'b01);
		wait_cyc(SYNC_N + 5);
		setin(2'b11);
		press(1'b1);
		wait_cyc(ACT_N + 2);
		outc(1'b0);
		st(ST_SYNC_ALERT_BIT, 1'b1, "sync alert");
		st(ST_ERR_BIT, 1'b1, "error");
		press(1'b0);
		setin(2'b00);
		wr(ADDR_CLEAR, 32'h1);
		st(ST_SYNC_ALERT_BIT, 1'b0, "sync alert");
		$display("test sync done");
		// Welded contact gives identical levels on input A
		@(posedge clk_i);
		stuck <= 2'b01;
		wait_cyc(SYNC_N + 5);
		st(ST_ANTIV_ALERT_BIT, 1'b1, "antivalence alert");
		st(ST_ERR_BIT, 1'b1, "error");
		@(posedge clk_i);
		stuck <= 2'b00;
		wr(ADDR_CLEAR, 32'h1);
		st(ST_ANTIV_ALERT_BIT, 1'b0, "antivalence alert");
		$display("test antivalence done");
		// B stays active past the interlock window
		setin(2'b11);
		press(1'b1);
		wait_cyc(ACT_N + 2);
		outc(1'b1);
		press(1'b0);
		setin(2'b10);
		wait_cyc(LOCK_N + 5);
		st(ST_LOCK_ALERT_BIT, 1'b1, "interlock alert");
		setin(2'b00);
		// B alone also ran out the sync time; clear it so only the interlock blocks
		wr(ADDR_CLEAR, 32'h1);
		wait_cyc(5);
		setin(2'b11);
		press(1'b1);
		wait_cyc(ACT_N + 2);
		outc(1'b0);
		press(1'b0);
		setin(2'b00);
		wait_cyc(CLR_N + 5);
		st(ST_LOCK_ALERT_BIT, 1'b0, "interlock alert");
		setin(2'b11);
		press(1'b1);
		wait_cyc(ACT_N + 2);
		outc(1'b1);
		press(1'b0);
		setin(2'b00);
		$display("test interlock done");
		wrap_up();
	end
endmodule : safety_input_evaluator_tb_top
